// File: rca_regs.svh
/*
  Register map, field positions, reset values and codes of the RC oscillation converter control.
  Assumes a 32-bit APB slave; included by the package and the design module.
*/
`ifndef RCA_REGS_SVH
`define RCA_REGS_SVH

`define RCA_TB_LOW_IDX     16'hF800
`define RCA_TB_HIGH_IDX    16'hF802
`define RCA_OC_LOW_IDX     16'hF804
`define RCA_OC_HIGH_IDX    16'hF806
`define RCA_MODE_IDX       16'hF808
`define RCA_RUN_IDX        16'hF80A
`define RCA_IRQ_STAT_IDX   16'hF810
`define RCA_IRQ_EN_IDX     16'hF812
`define RCA_IRQ_CLR_IDX    16'hF814
`define RCA_BLK_IDX        16'hF816
`define RCA_ADDR_W         18

`define RCA_OM_LSB         0
`define RCA_OM_MSB         3
`define RCA_OM_PROHIB_BIT  3
`define RCA_IRQSEL_BIT     4
`define RCA_CK_LSB         5
`define RCA_CK_MSB         7
`define RCA_RUN_BIT        0
`define RCA_BLK_BIT        0
`define RCA_ST_TB_BIT      0
`define RCA_ST_OC_BIT      1
`define RCA_ST_W           2

`define RCA_MODE_RST       16'h0000
`define RCA_RUN_RST        16'h0000
`define RCA_OM_EXT0        4'h0
`define RCA_OM_EXT1        4'h7
`define RCA_CK_LOW         3'h0
`define RCA_CK_HIGH        3'h1
`define RCA_CNT_W          24
`define RCA_DIV_W          6
`define RCA_HALF_W         16
`define RCA_UPPER_W        8

`endif

// File: rca_pkg.sv
/*
  Types of the RC oscillation converter control.
  Assumes rca_regs.svh is on the include path.
*/
`include "rca_regs.svh"
package rca_pkg;
  typedef struct packed {
    logic [15:0]           mode_config;
    logic                  conv_run;
    logic                  block_disable;
    logic [`RCA_CNT_W-1:0] tb_cnt;
    logic [`RCA_CNT_W-1:0] osc_cnt;
    logic [`RCA_CNT_W-1:0] tb_start;
    logic [`RCA_CNT_W-1:0] osc_start;
    logic [`RCA_DIV_W-1:0] div_cnt;
    logic [2:0]            clk_sync;
    logic [1:0]            lsc_sync;
    logic [`RCA_ST_W-1:0]  irq_stat;
    logic [`RCA_ST_W-1:0]  irq_en;
    logic                  irq_pulse;
    logic                  conv_irq;
    logic [31:0]           prdata;
    logic                  osc_enable;
    logic [3:0]            osc_mode_out;
  } rca_state_t;
endpackage : rca_pkg

// File: rca_ctrl.sv
/*
  Control, counting and APB register file of the RC oscillation converter.
  Assumes all inputs synchronous to sys_clk except the oscillator clocks, which are synchronised
  here; the analog oscillator and pin multiplexing sit outside.
*/
// How it works
// - Four-bit mode field picks external pin zero, RC pairs, pin one; top bit prohibited.
// - Interrupt source bit picks time-reference overflow at zero, oscillation overflow at one.
// - Three-bit field picks low-speed, high-speed, or high-speed divided by 2 to 64.
// - Run bit starts on one, stops on zero, reads zero after reset.
// - Either counter overflowing while running clears the run bit by hardware.
// - Time-reference counter is a 24-bit up-counter of the selected base clock.
// - Oscillation counter is a 24-bit up-counter of the selected oscillation clock.
// - Each counter has an overflow flag feeding the interrupt pulse through the source selection and the level through the enables.
// - With run at zero oscillators stay stopped and neither counter advances.
// - Setting run starts oscillation in the RC modes and both counters begin counting together.
// - Counters take a start value; reads give written value while running, count after.
// - A prohibited mode supplies no oscillator clock to the counters.
`timescale 1ns/10ps
`include "rca_regs.svh"
module rca_ctrl
  import rca_pkg::*;
(
  // Clock and reset.
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [17:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Clock sources.
  input  wire logic        low_speed_clock,
  input  wire logic        high_speed_clock,
  input  wire logic        ext_clk_in0,
  input  wire logic        ext_clk_in1,
  input  wire logic        rc_osc_clock,
  // Oscillator control and interrupt.
  output logic             osc_enable,
  output logic [3:0]       osc_mode_out,
  output logic             conv_irq,
  output logic             irq_pulse
);

  rca_state_t s_r;
  rca_state_t s_nxt;

  logic [3:0]            osc_mode_sel;
  logic                  irq_source_sel;
  logic [2:0]            base_clk_sel;
  logic                  osc_src;
  logic                  osc_edge;
  logic                  hs_edge;
  logic                  ls_edge;
  logic                  div_tick;
  logic                  tb_tick;
  logic                  timebase_overflow_flag;
  logic                  osc_overflow_flag;
  logic                  wr_en;
  logic                  rd_en;
  logic [`RCA_ADDR_W-1:0] a;
  logic [`RCA_DIV_W-1:0] div_mask;

  assign osc_mode_sel   = s_r.mode_config[`RCA_OM_MSB:`RCA_OM_LSB];
  assign irq_source_sel = s_r.mode_config[`RCA_IRQSEL_BIT];
  assign base_clk_sel   = s_r.mode_config[`RCA_CK_MSB:`RCA_CK_LSB];
  assign a              = paddr;
  assign wr_en          = psel & penable & pwrite;
  assign rd_en          = psel & ~penable & ~pwrite;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock source selection and edge detection.

  always_comb begin
    case (osc_mode_sel)
      `RCA_OM_EXT0: osc_src = ext_clk_in0;
      `RCA_OM_EXT1: osc_src = ext_clk_in1;
      default:      osc_src = osc_mode_sel[`RCA_OM_PROHIB_BIT] ? 1'b0 : rc_osc_clock;
    endcase
  end

  // The oscillator edge is taken between the second and third stages, the low-speed edge between the first and second.
  assign osc_edge = s_r.clk_sync[1] & ~s_r.clk_sync[2];
  assign ls_edge  = s_r.lsc_sync[0] & ~s_r.lsc_sync[1];
  assign hs_edge  = high_speed_clock;
  assign div_mask = `RCA_DIV_W'((1 << (base_clk_sel - `RCA_CK_HIGH)) - 1);
  assign div_tick = hs_edge && ((s_r.div_cnt & div_mask) == div_mask);

  always_comb begin
    case (base_clk_sel)
      `RCA_CK_LOW:  tb_tick = ls_edge;
      `RCA_CK_HIGH: tb_tick = hs_edge;
      default:      tb_tick = div_tick;
    endcase
  end

  assign timebase_overflow_flag = s_r.conv_run & tb_tick & (&s_r.tb_cnt);
  assign osc_overflow_flag = s_r.conv_run & osc_edge & ~osc_mode_sel[`RCA_OM_PROHIB_BIT]
                             & (&s_r.osc_cnt);

  ////////////////////////////////////////////////////////////////////////////////
  // Next state.

  always_comb begin
    s_nxt = s_r;
    s_nxt.clk_sync = {s_r.clk_sync[1:0], osc_src};
    s_nxt.lsc_sync = {s_r.lsc_sync[0], low_speed_clock};
    s_nxt.irq_pulse = 1'b0;
    if (hs_edge) begin
      s_nxt.div_cnt = s_r.div_cnt + `RCA_DIV_W'(1);
    end
    if (s_r.conv_run) begin
      if (tb_tick) begin
        s_nxt.tb_cnt = s_r.tb_cnt + `RCA_CNT_W'(1);
      end
      if (osc_edge && !osc_mode_sel[`RCA_OM_PROHIB_BIT]) begin
        s_nxt.osc_cnt = s_r.osc_cnt + `RCA_CNT_W'(1);
      end
      if (timebase_overflow_flag || osc_overflow_flag) begin
        s_nxt.conv_run = 1'b0;
      end
    end
    if (irq_source_sel ? osc_overflow_flag : timebase_overflow_flag) begin
      s_nxt.irq_pulse = 1'b1;
    end
    if (wr_en) begin
      case (a)
        `RCA_ADDR_W'(`RCA_TB_LOW_IDX << 2): begin
          s_nxt.tb_start[`RCA_HALF_W-1:0] = pwdata[`RCA_HALF_W-1:0];
          s_nxt.tb_cnt[`RCA_HALF_W-1:0]   = pwdata[`RCA_HALF_W-1:0];
        end
        `RCA_ADDR_W'(`RCA_TB_HIGH_IDX << 2): begin
          s_nxt.tb_start[`RCA_CNT_W-1:`RCA_HALF_W] = pwdata[`RCA_UPPER_W-1:0];
          s_nxt.tb_cnt[`RCA_CNT_W-1:`RCA_HALF_W]   = pwdata[`RCA_UPPER_W-1:0];
        end
        `RCA_ADDR_W'(`RCA_OC_LOW_IDX << 2): begin
          s_nxt.osc_start[`RCA_HALF_W-1:0] = pwdata[`RCA_HALF_W-1:0];
          s_nxt.osc_cnt[`RCA_HALF_W-1:0]   = pwdata[`RCA_HALF_W-1:0];
        end
        `RCA_ADDR_W'(`RCA_OC_HIGH_IDX << 2): begin
          s_nxt.osc_start[`RCA_CNT_W-1:`RCA_HALF_W] = pwdata[`RCA_UPPER_W-1:0];
          s_nxt.osc_cnt[`RCA_CNT_W-1:`RCA_HALF_W]   = pwdata[`RCA_UPPER_W-1:0];
        end
        `RCA_ADDR_W'(`RCA_MODE_IDX << 2): begin
          s_nxt.mode_config = {8'h00, pwdata[`RCA_CK_MSB:0]};
        end
        `RCA_ADDR_W'(`RCA_RUN_IDX << 2): begin
          s_nxt.conv_run = pwdata[`RCA_RUN_BIT] & ~s_r.block_disable;
        end
        `RCA_ADDR_W'(`RCA_IRQ_EN_IDX << 2): begin
          s_nxt.irq_en = pwdata[`RCA_ST_W-1:0];
        end
        `RCA_ADDR_W'(`RCA_BLK_IDX << 2): begin
          s_nxt.block_disable = pwdata[`RCA_BLK_BIT];
        end
        default: begin
        end
      endcase
    end
    if (s_r.block_disable) begin
      s_nxt.conv_run = 1'b0;
      s_nxt.tb_cnt   = '0;
      s_nxt.osc_cnt  = '0;
    end
    // Set wins over a clear in the same cycle.
    if (wr_en && a == `RCA_ADDR_W'(`RCA_IRQ_CLR_IDX << 2)) begin
      s_nxt.irq_stat = s_r.irq_stat & ~pwdata[`RCA_ST_W-1:0];
    end
    if (timebase_overflow_flag) begin
      s_nxt.irq_stat[`RCA_ST_TB_BIT] = 1'b1;
    end
    if (osc_overflow_flag) begin
      s_nxt.irq_stat[`RCA_ST_OC_BIT] = 1'b1;
    end
    s_nxt.conv_irq = |(s_nxt.irq_stat & s_nxt.irq_en);
    s_nxt.osc_enable = s_nxt.conv_run && !osc_mode_sel[`RCA_OM_PROHIB_BIT]
                       && osc_mode_sel != `RCA_OM_EXT0 && osc_mode_sel != `RCA_OM_EXT1;
    s_nxt.osc_mode_out = osc_mode_sel;
    s_nxt.prdata = '0;
    if (rd_en) begin
      case (a)
        `RCA_ADDR_W'(`RCA_TB_LOW_IDX << 2):
          s_nxt.prdata = {16'h0000, s_r.conv_run ? s_r.tb_start[15:0] : s_r.tb_cnt[15:0]};
        `RCA_ADDR_W'(`RCA_TB_HIGH_IDX << 2):
          s_nxt.prdata = {24'h000000, s_r.conv_run ? s_r.tb_start[23:16] : s_r.tb_cnt[23:16]};
        `RCA_ADDR_W'(`RCA_OC_LOW_IDX << 2):
          s_nxt.prdata = {16'h0000, s_r.conv_run ? s_r.osc_start[15:0] : s_r.osc_cnt[15:0]};
        `RCA_ADDR_W'(`RCA_OC_HIGH_IDX << 2):
          s_nxt.prdata = {24'h000000, s_r.conv_run ? s_r.osc_start[23:16] : s_r.osc_cnt[23:16]};
        `RCA_ADDR_W'(`RCA_MODE_IDX << 2):     s_nxt.prdata = {16'h0000, s_r.mode_config};
        `RCA_ADDR_W'(`RCA_RUN_IDX << 2):      s_nxt.prdata = {31'h0, s_r.conv_run};
        `RCA_ADDR_W'(`RCA_IRQ_STAT_IDX << 2): s_nxt.prdata = {30'h0, s_r.irq_stat};
        `RCA_ADDR_W'(`RCA_IRQ_EN_IDX << 2):   s_nxt.prdata = {30'h0, s_r.irq_en};
        `RCA_ADDR_W'(`RCA_BLK_IDX << 2):      s_nxt.prdata = {31'h0, s_r.block_disable};
        default:                              s_nxt.prdata = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Read data is registered from the setup cycle, so it stands while pready is high.
  logic rdy_r;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rdy_r <= 1'b0;
    end else begin
      rdy_r <= psel & ~penable;
    end
  end

  assign prdata       = s_r.prdata;
  assign pready       = rdy_r;
  assign pslverr      = 1'b0;
  assign osc_enable   = s_r.osc_enable;
  assign osc_mode_out = s_r.osc_mode_out;
  assign conv_irq     = s_r.conv_irq;
  assign irq_pulse    = s_r.irq_pulse;

endmodule : rca_ctrl

// File: rca_ctrl_checker.sv
/* Port assertions for rca_ctrl.
   Assumes the bind below and the register map header. */
`timescale 1ns/10ps
`include "rca_regs.svh"
module rca_ctrl_checker (
  // Watched ports.
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [17:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        osc_enable,
  input wire logic [3:0]  osc_mode_out,
  input wire logic        conv_irq,
  input wire logic        irq_pulse
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic wr_run;
  logic wr_clr;
  logic rc_mode;
  assign wr_run  = psel && penable && pready && pwrite && paddr == {`RCA_RUN_IDX, 2'b00};
  assign wr_clr  = psel && penable && pready && pwrite && paddr == {`RCA_IRQ_CLR_IDX, 2'b00};
  assign rc_mode = osc_mode_out inside {[4'h1:4'h6]};
  //////////////////////////////////////////////////////////////////////////////
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_no_slave_error: assert property (!pslverr)
    else $error("pslverr raised");
  a_idle_read_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside access");
  a_pulse_one_cycle: assert property (irq_pulse |=> !irq_pulse)
    else $error("irq pulse longer than one cycle");
  a_osc_valid_mode: assert property (osc_enable |-> rc_mode)
    else $error("oscillator enabled outside rc modes");
  a_stop_kills_osc: assert property (wr_run && !pwdata[0] |-> ##[1:3] !osc_enable)
    else $error("oscillator still on after stop");
  a_start_runs_osc: assert property (wr_run && pwdata[0] && rc_mode |-> ##[1:3] osc_enable)
    else $error("oscillator not started");
  a_overflow_stops: assert property (irq_pulse |-> ##[0:3] !osc_enable)
    else $error("oscillator on after overflow");
  a_clear_drops_irq: assert property (wr_clr && pwdata[1:0] == 2'h3 |-> ##[1:3] !conv_irq)
    else $error("irq still high after clear");
  c_pulse: cover property (irq_pulse);
  c_irq: cover property (conv_irq);
  c_osc: cover property (osc_enable);
endmodule : rca_ctrl_checker
bind rca_ctrl rca_ctrl_checker u_chk (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .osc_enable, .osc_mode_out, .conv_irq, .irq_pulse);

// File: rca_osc_model.sv
/* RC oscillator model: toggles its clock only while enabled.
   Assumes osc_enable from rca_ctrl in the sys_clk domain. */
`timescale 1ns/10ps
module rca_osc_model (
  input wire logic  sys_clk,
  input wire logic  osc_enable,
  output logic      rc_osc_clock
);
  logic ph;
  initial begin
    ph = 1'b0;
    rc_osc_clock = 1'b0;
  end
  // Stopped oscillator holds its clock low; running one has a four-cycle period.
  always @(posedge sys_clk) begin
    if (osc_enable !== 1'b1) begin
      ph <= 1'b0;
      rc_osc_clock <= 1'b0;
    end else begin
      ph <= ~ph;
      if (ph) rc_osc_clock <= ~rc_osc_clock;
    end
  end
endmodule : rca_osc_model

// File: rc_oscillation_adc_control_test.sv
/* Self-checking test of rca_ctrl over APB.
   Assumes the oscillator model and the checker are compiled alongside. */
`timescale 1ns/10ps
`include "rca_regs.svh"
module rc_oscillation_adc_control_test;
  localparam logic [15:0] TBL = `RCA_TB_LOW_IDX, TBH = `RCA_TB_HIGH_IDX, OCL = `RCA_OC_LOW_IDX,
    OCH = `RCA_OC_HIGH_IDX, MOD = `RCA_MODE_IDX, RUN = `RCA_RUN_IDX, STA = `RCA_IRQ_STAT_IDX,
    ENA = `RCA_IRQ_EN_IDX, CLR = `RCA_IRQ_CLR_IDX, BLK = `RCA_BLK_IDX;
  logic        sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [17:0] paddr = 18'h0;
  logic [31:0] pwdata = 32'h0, prdata, rdat, hold;
  logic        pready, pslverr, osc_enable, conv_irq, irq_pulse, rc_osc_clock;
  logic [3:0]  osc_mode_out;
  logic [3:0]  div = 4'h0;
  int          n_fail = 0, num_checks = 0, cyc = 0;
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) div <= div + 4'h1;
  rca_ctrl uut (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .low_speed_clock(div[3]), .high_speed_clock(1'b1), .ext_clk_in0(div[1]),
    .ext_clk_in1(div[2]), .rc_osc_clock, .osc_enable, .osc_mode_out, .conv_irq, .irq_pulse);
  rca_osc_model u_osc (.sys_clk, .osc_enable, .rc_osc_clock);
  //////////////////////////////////////////////////////////////////////////////
  task stop_test;
    if (n_fail == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : stop_test
  task chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk
  task apb(input logic [15:0] i, input logic w, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rdat = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb
  task rd(input logic [15:0] i, input logic [31:0] e, input string m);
    apb(i, 1'b0, 32'h0);
    chk(rdat === e, m);
  endtask : rd
  task wait_pulse;
    int k;
    k = 0;
    while (irq_pulse !== 1'b1 && k < 300) begin
      @(posedge sys_clk);
      k++;
    end
    chk(k < 300, "no irq pulse");
  endtask : wait_pulse
  task load(input logic [15:0] lo, input logic [31:0] v);
    apb(lo, 1'b1, {16'h0, v[15:0]});
    apb(lo + 16'h2, 1'b1, {24'h0, v[23:16]});
  endtask : load
  //////////////////////////////////////////////////////////////////////////////
  task t_reset;
    rd(MOD, 32'h0, "mode reset value");
    rd(RUN, 32'h0, "run reset value");
    rd(16'hF820, 32'h0, "unmapped read");
  endtask : t_reset
  task t_fields;
    apb(MOD, 1'b1, 32'hFFF7);
    rd(MOD, 32'hF7, "mode fields");
    chk(osc_mode_out === 4'h7, "mode output");
  endtask : t_fields
  task t_tb_ovf;
    apb(MOD, 1'b1, 32'h20);
    load(TBL, 32'hFFFFF0);
    load(OCL, 32'h0);
    apb(ENA, 1'b1, 32'h3);
    apb(RUN, 1'b1, 32'h1);
    rd(TBL, 32'hFFF0, "start value while running");
    wait_pulse;
    rd(RUN, 32'h0, "run not cleared");
    rd(STA, 32'h1, "timebase flag");
    chk(conv_irq === 1'b1, "irq level low");
    apb(OCL, 1'b0, 32'h0);
    chk(rdat[15:0] > 16'h0, "osc counter idle");
    apb(CLR, 1'b1, 32'h3);
    @(posedge sys_clk);
    chk(conv_irq === 1'b0, "irq not cleared");
  endtask : t_tb_ovf
  task t_osc_ovf;
    apb(MOD, 1'b1, 32'h11);
    load(OCL, 32'hFFFFF8);
    load(TBL, 32'h0);
    apb(ENA, 1'b1, 32'h0);
    apb(RUN, 1'b1, 32'h1);
    wait_pulse;
    chk(conv_irq === 1'b0, "masked irq raised");
    rd(STA, 32'h2, "osc flag");
    rd(RUN, 32'h0, "run not cleared");
    apb(ENA, 1'b1, 32'h2);
    chk(conv_irq === 1'b1, "enabled irq low");
    apb(CLR, 1'b1, 32'h3);
    @(posedge sys_clk);
    chk(conv_irq === 1'b0, "irq not cleared");
  endtask : t_osc_ovf
  task t_prohib;
    load(OCL, 32'h0);
    apb(MOD, 1'b1, 32'h8);
    apb(RUN, 1'b1, 32'h1);
    repeat (40) @(posedge sys_clk);
    chk(osc_enable === 1'b0, "oscillator on in bad mode");
    apb(RUN, 1'b1, 32'h0);
    rd(OCL, 32'h0, "bad mode counted");
    apb(TBL, 1'b0, 32'h0);
    hold = rdat;
    repeat (20) @(posedge sys_clk);
    rd(TBL, hold, "counter moved while stopped");
    apb(BLK, 1'b1, 32'h1);
    apb(BLK, 1'b1, 32'h0);
    rd(TBL, 32'h0, "block disable kept count");
  endtask : t_prohib
  task t_div;
    apb(MOD, 1'b1, 32'hE0);
    load(TBL, 32'h0);
    apb(RUN, 1'b1, 32'h1);
    repeat (640) @(posedge sys_clk);
    apb(RUN, 1'b1, 32'h0);
    apb(TBL, 1'b0, 32'h0);
    chk(rdat >= 32'h9 && rdat <= 32'hB, "divide by 64 count");
  endtask : t_div
  //////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      stop_test;
    end
  end
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset;
    t_fields;
    t_tb_ovf;
    t_osc_ovf;
    t_prohib;
    t_div;
    stop_test;
  end
endmodule : rc_oscillation_adc_control_test
